/* src/pmic_irq_pkg.sv */
// Purpose: shared constants and types for the interrupt and sequence register block
// Assumes: 250 MHz mclk, byte-wide registers reached over the two-wire control bus
// Notes: offsets are register addresses as seen on the bus
package pmic_irq_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEGLITCH_US = 32;
    localparam int DEGLITCH_NS = DEGLITCH_US * 1000;
    // least time, so round up
    localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h28;
    localparam logic [7:0] OFS_STATUS_ONE = 8'h29;
    localparam logic [7:0] OFS_ENABLE_TWO = 8'h2a;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h2b;
    localparam logic [7:0] OFS_SEQ_ONE = 8'h2c;

    // status one bit positions
    localparam int SP_BIT = 2;
    localparam int LP_BIT = 1;
    localparam int UV_BIT = 0;
    // enable two and status two bit positions
    localparam int FSD_BIT = 7;
    localparam int RISE_BIT = 6;
    localparam int FALL_BIT = 5;
    localparam int HOT_HI_BIT = 1;
    localparam int HOT_LO_BIT = 0;
    localparam logic [2:0] ENABLE_RESET = 3'h4;
    // priority field positions
    localparam int PRIO_W = 4;
    localparam int FIRST_PRIO_LSB = 0;
    localparam int SECOND_PRIO_LSB = 4;
    localparam logic [3:0] PRIO_OFF = 4'h0;
    localparam logic [3:0] PRIO_FIRST = 4'h1;
    localparam logic [3:0] PRIO_LAST = 4'hc;

    // flag vector indices
    localparam int NUM_FLAGS = 8;
    localparam int F_SHORT = 0;
    localparam int F_LONG = 1;
    localparam int F_UV = 2;
    localparam int F_FSD = 3;
    localparam int F_RISE = 4;
    localparam int F_FALL = 5;
    localparam int F_HOT_HI = 6;
    localparam int F_HOT_LO = 7;

    typedef struct packed {
        logic undervoltage;
        logic hot_high;
        logic hot_low;
    } analog_levels_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK = 3'b011,
        BUS_RX = 3'b010,
        BUS_TX = 3'b110,
        BUS_TX_ACK = 3'b111
    } bus_state_t;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_UP = 2'b01,
        SEQ_ON = 2'b11,
        SEQ_DOWN = 2'b10
    } seq_state_t;
endpackage

/* src/sticky_flag.sv */
// Purpose: one event flag, set by hardware and cleared by a register read
// Assumes: set and clear are single-cycle or level terms on mclk
// Notes: set wins over clear so an event in the clearing cycle is kept
`timescale 1ns/1ns
module sticky_flag
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_r
);
    always_ff @(posedge mclk)
    begin
        if (reset)
            flag_r <= 1'b0;
        else if (set_in)
            flag_r <= 1'b1;
        else if (clear_in)
            flag_r <= 1'b0;
    end
endmodule

/* src/deglitch.sv */
// Purpose: pass a level only after it has stayed put for CYCLES clocks
// Assumes: raw_in is synchronous to mclk
// Notes: any bounce restarts the count
`timescale 1ns/1ns
module deglitch
#(
    parameter int CYCLES = 8000
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic raw_in,
    output logic level_r
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_r;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            level_r <= 1'b0;
            count_r <= '0;
        end
        else if (raw_in == level_r)
            count_r <= '0;
        else if (count_r == CW'(CYCLES - 1))
        begin
            level_r <= raw_in;
            count_r <= '0;
        end
        else
            count_r <= count_r + CW'(1);
    end
endmodule

/* src/pmic_irq_and_sequence_regs.sv */
// Purpose: event flags, interrupt enables and buck sequencing behind the control bus
// Assumes: scl_in and sda_in are synchronous to mclk; power button is active high
// Notes: status registers clear on read; sda is open drain, low while sda_oe is high
`timescale 1ns/1ns
module pmic_irq_and_sequence_regs
#(
    parameter logic [6:0] DEV_ADDR = pmic_irq_pkg::DEV_ADDR_DEFAULT,
    parameter int DEGLITCH_CYC = pmic_irq_pkg::DEGLITCH_CYCLES,
    parameter int LONG_PRESS_CYC = 1000000,
    parameter int SHUTDOWN_CYC = 2000000,
    parameter int STEP_CYC = 250000,
    parameter logic [3:0] FIRST_PRIO_RESET = 4'h1,
    parameter logic [3:0] SECOND_PRIO_RESET = 4'h2
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe,
    input wire logic power_button_input,
    input wire pmic_irq_pkg::analog_levels_t analog_in,
    input wire logic power_on_request,
    input wire logic power_off_request,
    output logic irq_out,
    output logic [1:0] buck_enable
);
    import pmic_irq_pkg::*;

    localparam int TW = 32;

    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] flags;
    logic [2:0] enable_r;
    logic [PRIO_W-1:0] prio_r [2];
    logic button_db;
    logic button_q_r;
    logic [TW-1:0] press_cnt_r;
    logic long_done_r;
    logic fsd_done_r;
    logic fsd_pulse;

    // button path
    // input deglitch
    deglitch #(.CYCLES(DEGLITCH_CYC)) button_filter
    (
        .mclk(mclk),
        .reset(reset),
        .raw_in(power_button_input),
        .level_r(button_db)
    );

    always_ff @(posedge mclk)
    begin
        if (reset)
            button_q_r <= 1'b0;
        else
            button_q_r <= button_db;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            press_cnt_r <= '0;
            long_done_r <= 1'b0;
            fsd_done_r <= 1'b0;
        end
        else if (!button_db)
        begin
            press_cnt_r <= '0;
            long_done_r <= 1'b0;
            fsd_done_r <= 1'b0;
        end
        else
        begin
            if (press_cnt_r != TW'(SHUTDOWN_CYC))
                press_cnt_r <= press_cnt_r + TW'(1);
            if (press_cnt_r == TW'(LONG_PRESS_CYC))
                long_done_r <= 1'b1;
            if (fsd_pulse)
                fsd_done_r <= 1'b1;
        end
    end

    assign fsd_pulse = button_db && !fsd_done_r && press_cnt_r == TW'(SHUTDOWN_CYC);

    always_comb
    begin
        // short press ends before long time
        flag_set[F_SHORT] = button_q_r && !button_db && !long_done_r;
        flag_set[F_LONG] = button_db && !long_done_r && press_cnt_r == TW'(LONG_PRESS_CYC);
        flag_set[F_UV] = analog_in.undervoltage;
        flag_set[F_FSD] = fsd_pulse;
        flag_set[F_RISE] = button_db && !button_q_r;
        flag_set[F_FALL] = !button_db && button_q_r;
        flag_set[F_HOT_HI] = analog_in.hot_high;
        flag_set[F_HOT_LO] = analog_in.hot_low;
    end

    for (genvar g = 0; g < NUM_FLAGS; g++)
    begin : gen_flags
        sticky_flag flag_bit
        (
            .mclk(mclk),
            .reset(reset),
            .set_in(flag_set[g]),
            .clear_in(flag_clr[g]),
            .flag_r(flags[g])
        );
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_out <= 1'b0;
        else
            irq_out <= (flags[F_FSD] && enable_r[2]) || (flags[F_RISE] && enable_r[1])
                || (flags[F_FALL] && enable_r[0]);
    end

    // register read view
    logic [7:0] ptr_r;
    logic [7:0] rd_data;

    always_comb
    begin
        rd_data = 8'h00;
        case (ptr_r)
            OFS_STATUS_ONE:
            begin
                rd_data[SP_BIT] = flags[F_SHORT];
                rd_data[LP_BIT] = flags[F_LONG];
                rd_data[UV_BIT] = flags[F_UV];
            end
            OFS_ENABLE_TWO:
            begin
                rd_data[FSD_BIT] = enable_r[2];
                rd_data[RISE_BIT] = enable_r[1];
                rd_data[FALL_BIT] = enable_r[0];
            end
            OFS_STATUS_TWO:
            begin
                rd_data[FSD_BIT] = flags[F_FSD];
                rd_data[RISE_BIT] = flags[F_RISE];
                rd_data[FALL_BIT] = flags[F_FALL];
                rd_data[HOT_HI_BIT] = flags[F_HOT_HI];
                rd_data[HOT_LO_BIT] = flags[F_HOT_LO];
            end
            OFS_SEQ_ONE:
            begin
                rd_data[SECOND_PRIO_LSB +: PRIO_W] = prio_r[1];
                rd_data[FIRST_PRIO_LSB +: PRIO_W] = prio_r[0];
            end
            default:
                rd_data = 8'h00;
        endcase
    end

    // control bus slave
    bus_state_t bus_state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic read_dir_r;
    logic have_ptr_r;
    logic wr_pulse;
    logic rd_load;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    assign start_cond = scl_in && scl_q_r && sda_q_r && !sda_in;
    assign stop_cond = scl_in && scl_q_r && !sda_q_r && sda_in;
    assign scl_rise = scl_in && !scl_q_r;
    assign scl_fall = !scl_in && scl_q_r;
    assign wr_pulse = scl_fall && bus_state_r == BUS_RX && bit_cnt_r == 4'h8 && have_ptr_r;
    assign rd_load = scl_fall && read_dir_r
        && (bus_state_r == BUS_ACK || bus_state_r == BUS_TX_ACK);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            bus_state_r <= BUS_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            read_dir_r <= 1'b0;
            have_ptr_r <= 1'b0;
            ptr_r <= 8'h00;
            sda_oe <= 1'b0;
        end
        else if (start_cond)
        begin
            bus_state_r <= BUS_ADDR;
            bit_cnt_r <= 4'h0;
            have_ptr_r <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_cond)
        begin
            bus_state_r <= BUS_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (bus_state_r)
                BUS_ADDR, BUS_RX:
                begin
                    if (scl_rise && bit_cnt_r != 4'h8)
                    begin
                        shift_r <= {shift_r[6:0], sda_in};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == 4'h8)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (bus_state_r == BUS_ADDR && shift_r[7:1] != DEV_ADDR)
                            bus_state_r <= BUS_IDLE;
                        else
                        begin
                            bus_state_r <= BUS_ACK;
                            sda_oe <= 1'b1;
                            if (bus_state_r == BUS_ADDR)
                                read_dir_r <= shift_r[0];
                            else if (!have_ptr_r)
                            begin
                                ptr_r <= shift_r;
                                have_ptr_r <= 1'b1;
                            end
                            else
                                ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                BUS_ACK, BUS_TX_ACK:
                begin
                    if (scl_rise && bus_state_r == BUS_TX_ACK && sda_in)
                        bus_state_r <= BUS_IDLE;
                    else if (scl_fall && read_dir_r)
                    begin
                        // first data bit goes out as ack ends
                        shift_r <= rd_data;
                        sda_oe <= !rd_data[7];
                        bit_cnt_r <= 4'h1;
                        ptr_r <= ptr_r + 8'h01;
                        bus_state_r <= BUS_TX;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        bus_state_r <= BUS_RX;
                    end
                end
                BUS_TX:
                begin
                    if (scl_fall && bit_cnt_r == 4'h8)
                    begin
                        sda_oe <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        bus_state_r <= BUS_TX_ACK;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe <= !shift_r[6];
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                default:
                    sda_oe <= 1'b0;
            endcase
        end
    end

    // status registers clear when their byte is loaded for the host
    always_comb
    begin
        flag_clr = '0;
        if (rd_load && ptr_r == OFS_STATUS_ONE)
        begin
            flag_clr[F_SHORT] = 1'b1;
            flag_clr[F_LONG] = 1'b1;
            flag_clr[F_UV] = 1'b1;
        end
        if (rd_load && ptr_r == OFS_STATUS_TWO)
        begin
            flag_clr[F_FSD] = 1'b1;
            flag_clr[F_RISE] = 1'b1;
            flag_clr[F_FALL] = 1'b1;
            flag_clr[F_HOT_HI] = 1'b1;
            flag_clr[F_HOT_LO] = 1'b1;
        end
    end

    // writable registers
    always_ff @(posedge mclk)
    begin
        if (reset)
            enable_r <= ENABLE_RESET;
        else if (wr_pulse && ptr_r == OFS_ENABLE_TWO)
            enable_r <= {shift_r[FSD_BIT], shift_r[RISE_BIT], shift_r[FALL_BIT]};
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prio_r[0] <= FIRST_PRIO_RESET;
            prio_r[1] <= SECOND_PRIO_RESET;
        end
        else if (wr_pulse && ptr_r == OFS_SEQ_ONE)
        begin
            prio_r[0] <= shift_r[FIRST_PRIO_LSB +: PRIO_W];
            prio_r[1] <= shift_r[SECOND_PRIO_LSB +: PRIO_W];
        end
    end

    // buck sequencer
    seq_state_t seq_state_r;
    logic [3:0] step_r;
    logic [TW-1:0] step_timer_r;
    logic step_tick;

    assign step_tick = step_timer_r == TW'(STEP_CYC - 1);

    always_ff @(posedge mclk)
    begin
        if (reset || seq_state_r == SEQ_OFF || seq_state_r == SEQ_ON || step_tick)
            step_timer_r <= '0;
        else
            step_timer_r <= step_timer_r + TW'(1);
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            seq_state_r <= SEQ_OFF;
            step_r <= PRIO_FIRST;
        end
        else
        begin
            case (seq_state_r)
                SEQ_OFF:
                    if (power_on_request && !fsd_pulse)
                    begin
                        seq_state_r <= SEQ_UP;
                        step_r <= PRIO_FIRST;
                    end
                SEQ_UP:
                    if (fsd_pulse || power_off_request)
                        seq_state_r <= SEQ_DOWN;
                    else if (step_tick && step_r == PRIO_LAST)
                        seq_state_r <= SEQ_ON;
                    else if (step_tick)
                        step_r <= step_r + 4'h1;
                SEQ_ON:
                    if (fsd_pulse || power_off_request)
                    begin
                        seq_state_r <= SEQ_DOWN;
                        step_r <= PRIO_LAST;
                    end
                SEQ_DOWN:
                    if (step_tick && step_r == PRIO_FIRST)
                        seq_state_r <= SEQ_OFF;
                    else if (step_tick)
                        step_r <= step_r - 4'h1;
                default:
                    seq_state_r <= SEQ_OFF;
            endcase
        end
    end

    for (genvar b = 0; b < 2; b++)
    begin : gen_bucks
        always_ff @(posedge mclk)
        begin
            if (reset)
                buck_enable[b] <= 1'b0;
            else if (seq_state_r == SEQ_UP && step_tick && prio_r[b] == step_r
                && prio_r[b] != PRIO_OFF)
                buck_enable[b] <= 1'b1;
            else if (seq_state_r == SEQ_DOWN && step_tick && prio_r[b] >= step_r)
                buck_enable[b] <= 1'b0;
        end
    end
endmodule

/* verification/pmic_irq_asserts.sv */
// Purpose: port checks for the irq and sequence register block
// Assumes: STEP_CYC equals the instance value
// Notes: bound below the module
`timescale 1ns/1ns
module pmic_irq_asserts
#(
    parameter int STEP_CYC = 250000
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic power_button_input,
    input wire logic power_on_request,
    input wire logic irq_out,
    input wire logic [1:0] buck_enable
);
    logic scl_prev_r;
    logic btn_seen_r;
    logic last_up_r;
    logic [1:0] buck_prev_r;
    int fall_age_r;
    int on_age_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    always_ff @(posedge mclk)
    begin
        scl_prev_r <= scl_in;
        buck_prev_r <= buck_enable;
    end
    // saturating ages, large after reset so nothing is excused
    always_ff @(posedge mclk)
    begin
        if (reset || !(scl_prev_r && !scl_in))
            fall_age_r <= (reset || fall_age_r > 9999) ? 10000 : fall_age_r + 1;
        else
            fall_age_r <= 0;
    end
    always_ff @(posedge mclk)
    begin
        if (reset || !power_on_request)
            on_age_r <= (reset || on_age_r > 9999) ? 10000 : on_age_r + 1;
        else
            on_age_r <= 0;
    end
    always_ff @(posedge mclk)
    begin
        btn_seen_r <= !reset && (btn_seen_r || power_button_input);
    end
    always_ff @(posedge mclk)
    begin
        if (buck_enable[1] && !buck_prev_r[1])
            last_up_r <= 1'b1;
        else if (buck_enable[0] && !buck_prev_r[0])
            last_up_r <= 1'b0;
    end
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |=> !sda_oe && !irq_out && buck_enable == 2'b00) else $error("not quiet after reset");
    a_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("sda driven change while scl high");
    a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*3])
        else $error("sda pull too short");
    a_irq_fall_read: assert property ($fell(irq_out) |-> fall_age_r <= 6)
        else $error("irq dropped without bus access");
    a_irq_needs_press: assert property ($rose(irq_out) |-> btn_seen_r)
        else $error("irq with no button activity");
    a_step_gap: assert property ($changed(buck_enable) |=> $stable(buck_enable) [*3])
        else $error("buck steps too close");
    a_up_after_request: assert property (|(buck_enable & ~buck_prev_r) |->
        on_age_r <= 13 * STEP_CYC + 4) else $error("buck on without request");
    a_down_reverse: assert property (buck_prev_r == 2'b11 && buck_enable == 2'b01
        || buck_prev_r == 2'b11 && buck_enable == 2'b10 |-> !buck_enable[last_up_r])
        else $error("power down not reversed");
    c_ack: cover property ($rose(sda_oe));
    c_irq: cover property ($rose(irq_out));
    c_both_on: cover property (buck_enable == 2'b11);
endmodule
bind pmic_irq_and_sequence_regs pmic_irq_asserts #(.STEP_CYC(STEP_CYC)) i_chk (.mclk(mclk),
    .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe), .power_button_input(power_button_input),
    .power_on_request(power_on_request), .irq_out(irq_out), .buck_enable(buck_enable));

/* verification/i2c_host_model.sv */
// Purpose: two-wire bus host driving the register block
// Assumes: bit time of 8 mclk, wire pulled up when released
// Notes: sda_drv low pulls the wire, high releases it
`timescale 1ns/1ns
module i2c_host_model
(
    input wire logic mclk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_wire
);
    import pmic_irq_pkg::*;
    int nak_count = 0;
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        hold(2);
        scl = 1'b1;
        hold(4);
        sda_drv = 1'b0;
        hold(4);
        scl = 1'b0;
        hold(2);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        hold(2);
        scl = 1'b1;
        hold(4);
        sda_drv = 1'b1;
        hold(4);
    endtask
    // ninth bit released: ack slot, or host nack when reading
    task automatic xfer(input logic [7:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            sda_drv = (i == 0) ? 1'b1 : d[i-1];
            hold(2);
            scl = 1'b1;
            hold(4);
            r[i] = sda_wire;
            scl = 1'b0;
            hold(2);
        end
    endtask
    task automatic send(input logic [7:0] d);
        logic [8:0] r;
        xfer(d, r);
        if (r[0] !== 1'b0)
            nak_count++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        send(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic [8:0] r;
        start();
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        start();
        send({DEV_ADDR_DEFAULT, 1'b1});
        xfer(8'hff, r);
        q = r[8:1];
        stop();
    endtask
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench for the irq and sequence register block
// Assumes: shortened counts, host model on the bus
// Notes: exp holds the expected register image
`timescale 1ns/1ns
module tb_top;
    import pmic_irq_pkg::*;
    logic mclk = 0;
    logic reset = 1;
    logic btn = 0, on_req = 0, off_req = 0;
    logic scl, sda_drv, sda_oe, sda_wire, irq;
    logic [1:0] buck, prev;
    logic [7:0] q;
    logic [7:0] addrs[5] = '{8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30};
    analog_levels_t lv = '0;
    int err_count = 0, n_compared = 0, cyc = 0;
    int exp[int];
    int t_on[2], t_off[2];
    assign sda_wire = sda_drv & ~sda_oe;
    always #2 mclk = ~mclk;
    pmic_irq_and_sequence_regs #(.DEGLITCH_CYC(4), .LONG_PRESS_CYC(50), .SHUTDOWN_CYC(100),
        .STEP_CYC(4)) i_dut (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_oe(sda_oe), .power_button_input(btn), .analog_in(lv), .power_on_request(on_req),
        .power_off_request(off_req), .irq_out(irq), .buck_enable(buck));
    i2c_host_model i_host (.mclk(mclk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
    always @(negedge mclk)
    begin
        cyc++;
        for (int i = 0; i < 2; i++)
        begin
            if (buck[i] && !prev[i]) t_on[i] = cyc;
            if (!buck[i] && prev[i]) t_off[i] = cyc;
        end
        prev = buck;
        if (cyc == 40000)
        begin
            err_count++;
            results();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // flags clear on read; live levels set them again
    task automatic rdc(input logic [7:0] a);
        i_host.rd(a, q);
        check(q, exp.exists(a) ? 8'(exp[a]) : 8'h00);
        if (a == OFS_STATUS_ONE) exp[a] = lv.undervoltage;
        if (a == OFS_STATUS_TWO) exp[a] = {lv.hot_high, lv.hot_low};
    endtask
    task automatic press(input int n);
        @(negedge mclk) btn = 1;
        repeat (n) @(negedge mclk);
        btn = 0;
        repeat (60) @(negedge mclk);
    endtask
    task automatic req(input bit up);
        @(negedge mclk) {on_req, off_req} = up ? 2'b10 : 2'b01;
        @(negedge mclk) {on_req, off_req} = 2'b00;
        repeat (80) @(negedge mclk);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        void'($urandom(94512));
        exp[OFS_ENABLE_TWO] = 'h80;
        exp[OFS_SEQ_ONE] = 'h21;
        repeat (8) @(negedge mclk);
        reset = 0;
        foreach (addrs[i]) rdc(addrs[i]);
        $display("test reset image done");
        q = 8'($urandom);
        i_host.wr(OFS_ENABLE_TWO, q);
        exp[OFS_ENABLE_TWO] = q & 8'he0;
        i_host.wr(OFS_STATUS_TWO, 8'hff);
        rdc(OFS_ENABLE_TWO);
        rdc(OFS_STATUS_TWO);
        q = 8'($urandom);
        i_host.wr(OFS_SEQ_ONE, q);
        exp[OFS_SEQ_ONE] = q;
        rdc(OFS_SEQ_ONE);
        // foreign address: three bytes left unacknowledged, nothing written
        i_host.start();
        i_host.send({DEV_ADDR_DEFAULT + 7'h1, 1'b0});
        i_host.send(OFS_SEQ_ONE);
        i_host.send(~q);
        i_host.stop();
        rdc(OFS_SEQ_ONE);
        $display("test access done");
        i_host.wr(OFS_ENABLE_TWO, 8'h60);
        exp[OFS_ENABLE_TWO] = 'h60;
        press($urandom_range(2, 1));
        rdc(OFS_STATUS_ONE);
        press(20);
        exp[OFS_STATUS_ONE] = 'h04;
        exp[OFS_STATUS_TWO] = 'h60;
        check({7'h0, irq}, 8'h01);
        rdc(OFS_STATUS_ONE);
        rdc(OFS_STATUS_TWO);
        check({7'h0, irq}, 8'h00);
        rdc(OFS_STATUS_ONE);
        $display("test short press done");
        lv = 3'b111;
        repeat (4) @(negedge mclk);
        exp[OFS_STATUS_ONE] = 'h01;
        exp[OFS_STATUS_TWO] = 'h03;
        rdc(OFS_STATUS_ONE);
        lv = 3'b000;
        repeat (2) rdc(OFS_STATUS_TWO);
        repeat (2) rdc(OFS_STATUS_ONE);
        $display("test levels done");
        i_host.wr(OFS_ENABLE_TWO, 8'h80);
        i_host.wr(OFS_SEQ_ONE, 8'h31);
        exp[OFS_ENABLE_TWO] = 'h80;
        req(1);
        check({6'h0, buck}, 8'h03);
        check(8'(t_on[0] < t_on[1]), 8'h01);
        press(130);
        check({7'h0, irq}, 8'h01);
        check({6'h0, buck}, 8'h00);
        check(8'(t_off[1] < t_off[0]), 8'h01);
        exp[OFS_STATUS_ONE] = 'h02;
        exp[OFS_STATUS_TWO] = 'he0;
        rdc(OFS_STATUS_ONE);
        rdc(OFS_STATUS_TWO);
        $display("test forced shutdown done");
        // off request while still ramping up walks back from the current step
        @(negedge mclk) on_req = 1;
        @(negedge mclk) on_req = 0;
        repeat (6) @(negedge mclk);
        check({6'h0, buck}, 8'h01);
        req(0);
        check({6'h0, buck}, 8'h00);
        i_host.wr(OFS_SEQ_ONE, 8'h0c);
        req(1);
        check({6'h0, buck}, 8'h01);
        req(0);
        check({6'h0, buck}, 8'h00);
        check(8'(i_host.nak_count), 8'h03);
        $display("test priority ends done");
        results();
    end
endmodule
